//--- bench/remote_terminal.sv
`timescale 1ns/1ns
module remote_terminal #(
  parameter int BIT_CYC = 8
) (
  // Clock and serial lines
  input  wire logic clk_i,
  input  wire logic tx_line_i,
  output logic      rx_line_o
);
  logic [11:0] frame_bits;
  int          frame_count;
  int          start_len;

  initial begin
    rx_line_o   = 1'h1;
    frame_bits  = '0;
    frame_count = 0;
    start_len   = 0;
  end

  // Start bit, then n bits from bit 0 up, then the line idles high
  task automatic send_frame(input logic [11:0] bits, input int n);
    @(posedge clk_i);
    rx_line_o <= 1'h0;
    repeat (BIT_CYC) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      rx_line_o <= bits[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    rx_line_o <= 1'h1;
  endtask : send_frame

  // Times the start bit, then samples the next twelve bits at mid-bit
  always begin
    @(posedge clk_i iff tx_line_i === 1'h0);
    start_len = 0;
    while (tx_line_i === 1'h0 && start_len < 300) begin
      start_len++;
      @(posedge clk_i);
    end
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 12; i++) begin
      frame_bits[i] = tx_line_i;
      repeat (BIT_CYC) @(posedge clk_i);
    end
    frame_count++;
  end
endmodule : remote_terminal

//--- bench/testbench.sv
`timescale 1ns/1ns
`include "serial_chan_defs.svh"
module testbench;
  localparam int DIV     = 3;
  localparam int BIT_CYC = 2 * DIV + 2;
  logic        clk_i;
  logic        rst_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        last_err;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe;
  logic        irq;
  logic        tx_wire;
  logic        rx_line;
  logic [31:0] rdata;
  logic [11:0] f;
  logic [15:0] cfg [4];
  logic [8:0]  chr [4];
  int          cnt;
  int          cycles;
  int          miscompares;
  int          check_count;

  // Transmit pin has a pull-up while not driven
  assign tx_wire = pin_oe[4] ? pin_out[4] : 1'h1;

  async_serial_channel async_serial_channel_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .port5_in_i({2'h3, rx_line, 5'h1F}), .port5_out_o(pin_out), .port5_oe_o(pin_oe),
    .irq_o(irq)
  );

  remote_terminal #(.BIT_CYC(BIT_CYC)) remote_terminal_i (
    .clk_i(clk_i), .tx_line_i(tx_wire), .rx_line_o(rx_line)
  );

  always #25 clk_i = ~clk_i;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'h1;
    // Wait for the answer; only the bench timeout ends a hang
    do begin
      @(posedge clk_i);
    end while (pready !== 1'h1);
    rdata    = prdata;
    last_err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'h0, a, 32'h0);
    check(rdata, exp, what);
  endtask : rd_check

  task automatic wait_frame(input int c);
    int n;
    n = 0;
    while (remote_terminal_i.frame_count == c && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    check(32'(n < 3000), 32'h1, "frame seen");
  endtask : wait_frame

  // Line bits after the start bit for one character, idle ones after the stops
  function automatic logic [11:0] frame_of(input logic [8:0] ch, input logic [15:0] c);
    int         n;
    logic [8:0] d;
    logic [11:0] r;
    n = (c[1:0] == 2'h1) ? 9 : (c[1:0] == 2'h2) ? 7 : 8;
    d = ch & ((9'h1 << n) - 9'h1);
    r = '1;
    for (int i = 0; i < n; i++) r[i] = c[7] ? d[i] : d[n - 1 - i];
    if (c[9:8] != 2'h0) r[n] = (c[9:8] == 2'h1) ? 1'h0 : (c[9:8] == 2'h2) ? ^d : ~^d;
    return r;
  endfunction : frame_of

  task automatic rx_case(input logic [11:0] bits, input logic [31:0] sts);
    remote_terminal_i.send_frame(bits, 10);
    repeat (4) @(posedge clk_i);
    rd_check(`OFS_IRQ_STS, sts, "rx status");
    apb(1'h0, `OFS_DATA, 32'h0);
    wr(`OFS_IRQ_STS, 32'h1F);
  endtask : rx_case

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    clk_i = 1'h0;
    rst_i = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cycles = 0;
    miscompares = 0;
    check_count = 0;
    cfg = '{16'hC093, 16'hC222, 16'hC391, 16'hC103};
    chr = '{9'h0A5, 9'h165, 9'h1A5, 9'h1A5};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    rd_check(`OFS_OUT_LVL, 32'h1, "level reset");
    rd_check(`OFS_DIR, 32'hFF, "port mode reset");
    rd_check(`OFS_COMM, 32'h0, "comm reset");
    wr(`OFS_START, 32'h0);
    rd_check(`OFS_START, 32'h0, "start by zero");
    wr(`OFS_LATCH, 32'h0);
    wr(`OFS_DIR, 32'hEF);
    repeat (3) @(posedge clk_i);
    check(32'(pin_oe), 32'h10, "pin drive");
    check(32'(pin_out[4]), 32'h0, "latch low");
    wr(`OFS_LATCH, 32'h10);
    wr(`OFS_OUT_LVL, 32'h0);
    repeat (3) @(posedge clk_i);
    check(32'(pin_out[4]), 32'h0, "level low");
    wr(`OFS_OUT_LVL, 32'h1);
    repeat (3) @(posedge clk_i);
    check(32'(pin_out[4]), 32'h1, "level high");
    $display("test pins done");
    // The low pin checks look like a start bit: let the far side finish that frame
    repeat (16 * BIT_CYC) @(posedge clk_i);
    wr(`OFS_MODE, 32'h102);
    wr(`OFS_COMM, 32'hC093);
    wr(`OFS_OUT_EN, 32'h1);
    repeat (4) @(posedge clk_i);
    wr(`OFS_START, 32'h1);
    rd_check(`OFS_START, 32'h1, "enable status");
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_COMM, {16'h0, cfg[i]});
      cnt = remote_terminal_i.frame_count;
      wr(`OFS_DATA, {16'h0, 7'(DIV), chr[i]});
      wait_frame(cnt);
      f = frame_of(chr[i], cfg[i]);
      check(32'(remote_terminal_i.frame_bits), 32'(f), "frame");
      check(32'(remote_terminal_i.start_len), 32'(BIT_CYC), "bit time");
      repeat (2 * BIT_CYC) @(posedge clk_i);
      rd_check(`OFS_IRQ_STS, 32'h1, "tx end status");
      check(32'(irq), 32'h0, "masked irq");
      wr(`OFS_IRQ_STS, 32'h1);
    end
    $display("test transmit done");
    wr(`OFS_IRQ_MSK, 32'h1);
    wr(`OFS_MODE, 32'h103);
    cnt = remote_terminal_i.frame_count;
    wr(`OFS_DATA, {16'h0, 7'(DIV), 9'h0A5});
    rd_check(`OFS_IRQ_STS, 32'h1, "buffer empty status");
    check(32'(irq), 32'h1, "irq raised");
    wait_frame(cnt);
    repeat (2 * BIT_CYC) @(posedge clk_i);
    wr(`OFS_IRQ_STS, 32'h1);
    repeat (2) @(posedge clk_i);
    check(32'(irq), 32'h0, "irq cleared");
    wr(`OFS_OUT_EN, 32'h0);
    cnt = remote_terminal_i.frame_count;
    wr(`OFS_DATA, {16'h0, 7'(DIV), 9'h0A5});
    repeat (14 * BIT_CYC) @(posedge clk_i);
    check(32'(remote_terminal_i.frame_count), 32'(cnt), "output stopped");
    wr(`OFS_OUT_EN, 32'h1);
    wr(`OFS_IRQ_STS, 32'h1F);
    $display("test irq done");
    wr(`OFS_MODE, 32'h102);
    wr(`OFS_COMM, 32'h4693);
    wr(`OFS_IRQ_MSK, 32'h6);
    repeat (4) @(posedge clk_i);
    wr(`OFS_START, 32'h1);
    remote_terminal_i.send_frame(frame_of(9'h03C, 16'h4693), 10);
    repeat (4) @(posedge clk_i);
    check(32'(irq), 32'h1, "rx irq");
    rd_check(`OFS_IRQ_STS, 32'h2, "rx done");
    rd_check(`OFS_DATA, {16'h0, 7'(DIV), 9'h03C}, "rx data");
    wr(`OFS_IRQ_STS, 32'h1F);
    f = frame_of(9'h03C, 16'h4693);
    f[8] = ~f[8];
    rx_case(f, 32'h6);
    wr(`OFS_COMM, 32'h4293);
    rx_case(f, 32'h2);
    cnt = remote_terminal_i.frame_count;
    wr(`OFS_DATA, {16'h0, 7'(DIV), 9'h0A5});
    repeat (14 * BIT_CYC) @(posedge clk_i);
    check(32'(remote_terminal_i.frame_count), 32'(cnt), "rx only mode");
    wr(`OFS_MODE, 32'h2);
    remote_terminal_i.send_frame(frame_of(9'h03C, 16'h4293), 10);
    repeat (4) @(posedge clk_i);
    rd_check(`OFS_IRQ_STS, 32'h0, "no pin start");
    wr(`OFS_START, 32'h1);
    repeat (2 * BIT_CYC) @(posedge clk_i);
    rd_check(`OFS_IRQ_STS, 32'h0, "trigger on idle line");
    $display("test receive done");
    apb(1'h0, 8'h30, 32'h0);
    check({31'h0, last_err}, 32'h1, "unmapped error");
    check(rdata, 32'h0, "unmapped data");
    $display("test unmapped done");
    finish_test();
  end
endmodule : testbench

//--- src/async_serial_channel.sv
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ns
`include "serial_chan_defs.svh"

module async_serial_channel (
  // Clock, reset and enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Port 5 pins
  input  wire logic [7:0]  port5_in_i,
  output logic      [7:0]  port5_out_o,
  output logic      [7:0]  port5_oe_o,
  // Interrupt
  output logic             irq_o
);
  import serial_chan_pkg::*;

  chan_state_s st;
  chan_state_s next_st;
  logic        wr_en;
  logic        trig;
  logic        run_tx;
  logic        run_rx;
  logic        rx_lvl;
  logic        start_edge;
  logic        rx_done;
  logic        tx_done;
  logic        frame_bit;
  logic        par_bit;
  logic [3:0]  len;
  logic [8:0]  len_mask;
  logic [7:0]  bit_period;
  logic [4:0]  ev;
  logic [4:0]  clr;

  function automatic logic [3:0] char_len(input logic [1:0] code);
    unique case (code)
      `DLEN_9: char_len = 4'h9;
      `DLEN_7: char_len = 4'h7;
      default: char_len = 4'h8;
    endcase
  endfunction : char_len

  // Position in the character of the k-th bit on the line
  function automatic logic [3:0] bit_pos(input logic lsb_first, input logic [3:0] n,
                                         input logic [3:0] k);
    bit_pos = lsb_first ? k : 4'(n - 4'h1 - k);
  endfunction : bit_pos

  always_comb begin
    next_st    = st;
    ev         = 5'h00;
    clr        = 5'h00;
    trig       = 1'b0;
    tx_done    = 1'b0;
    rx_done    = 1'b0;
    frame_bit  = 1'b1;
    len        = char_len(st.dlen);
    len_mask   = 9'h1FF >> (4'h9 - len);
    bit_period = {st.divider, 1'b1};
    run_tx     = st.enabled && st.txe && st.ch_mode == `CH_MODE_UART;
    run_rx     = st.enabled && st.rxe && st.ch_mode == `CH_MODE_UART;
    rx_lvl     = st.rx_sync ^ st.rx_inv;
    start_edge = (st.rx_prev ^ st.rx_inv) && !rx_lvl;
    wr_en      = psel_i && penable_i && st.pready && pwrite_i;

    // Receive pin synchroniser
    next_st.rx_meta = port5_in_i[`PIN_RX];
    next_st.rx_sync = st.rx_meta;
    next_st.rx_prev = st.rx_sync;

    // Bus answer: data captured in setup, ready in the access cycle
    next_st.pready = psel_i && !penable_i;
    if (psel_i && !penable_i) begin
      next_st.pslverr = 1'b0;
      next_st.prdata  = 32'h0;
      if (!pwrite_i && paddr_i == `OFS_DATA) begin
        next_st.rx_full = 1'b0;
      end
      unique case (paddr_i)
        `OFS_MODE:    next_st.prdata = {23'h0, st.sts, 1'b0, st.rx_inv, 3'h0, st.ch_mode,
                                        st.irq_sel};
        `OFS_COMM:    next_st.prdata = {16'h0, st.txe, st.rxe, 3'h0, st.eoc, st.par, st.dir,
                                        1'b0, st.stop, 2'h0, st.dlen};
        `OFS_DATA:    next_st.prdata = {16'h0, st.divider, st.rx_data};
        `OFS_OUT_LVL: next_st.prdata = {31'h0, st.so_lvl};
        `OFS_OUT_EN:  next_st.prdata = {31'h0, st.soe};
        `OFS_START:   next_st.prdata = {31'h0, st.enabled};
        `OFS_LATCH:   next_st.prdata = {24'h0, st.latch};
        `OFS_DIR:     next_st.prdata = {24'h0, st.pmode};
        `OFS_IRQ_STS: next_st.prdata = {27'h0, st.ists};
        `OFS_IRQ_MSK: next_st.prdata = {27'h0, st.imask};
        default:      next_st.pslverr = 1'b1;
      endcase
    end

    // Register writes at the completing access edge
    if (wr_en) begin
      unique case (paddr_i)
        `OFS_MODE: begin
          next_st.irq_sel = pwdata_i[0];
          next_st.ch_mode = pwdata_i[2:1];
          next_st.rx_inv  = pwdata_i[6];
          next_st.sts     = pwdata_i[8];
        end
        `OFS_COMM: begin
          next_st.txe  = pwdata_i[15];
          next_st.rxe  = pwdata_i[14];
          next_st.eoc  = pwdata_i[10];
          next_st.par  = pwdata_i[9:8];
          next_st.dir  = pwdata_i[7];
          next_st.stop = pwdata_i[5:4];
          next_st.dlen = pwdata_i[1:0];
        end
        `OFS_DATA: begin
          next_st.divider = pwdata_i[15:9];
          // A character written while the buffer is still full is dropped
          if (run_tx && !st.tx_full) begin
            next_st.tx_buf  = pwdata_i[8:0];
            next_st.tx_full = 1'b1;
          end
        end
        `OFS_OUT_LVL: next_st.so_lvl = pwdata_i[0];
        `OFS_OUT_EN:  next_st.soe    = pwdata_i[0];
        `OFS_START: begin
          if (pwdata_i[`START_GO]) begin
            next_st.enabled = 1'b1;
            trig            = 1'b1;
          end else if (pwdata_i[`START_HALT]) begin
            next_st.enabled = 1'b0;
          end
        end
        `OFS_LATCH:   next_st.latch = pwdata_i[7:0];
        `OFS_DIR:     next_st.pmode = pwdata_i[7:0];
        `OFS_IRQ_STS: clr           = pwdata_i[4:0];
        `OFS_IRQ_MSK: next_st.imask = pwdata_i[4:0];
        default: ;
      endcase
    end

    // Transmitter
    if (st.tx_state != tx_idle) begin
      next_st.tx_cnt = st.tx_cnt - 8'h01;
    end
    unique case (st.tx_state)
      tx_idle: begin
        if (run_tx && st.tx_full) begin
          next_st.tx_shift = st.tx_buf;
          next_st.tx_full  = 1'b0;
          next_st.tx_cnt   = bit_period;
          next_st.tx_state = tx_start;
          ev[`IRQ_TX]      = st.irq_sel;
        end
      end
      tx_start: begin
        if (st.tx_cnt == 8'h00) begin
          next_st.tx_cnt   = bit_period;
          next_st.tx_bit   = 4'h0;
          next_st.tx_state = tx_data;
        end
      end
      tx_data: begin
        if (st.tx_cnt == 8'h00) begin
          next_st.tx_cnt = bit_period;
          next_st.tx_bit = st.tx_bit + 4'h1;
          if (st.tx_bit == len - 4'h1) begin
            next_st.tx_bit = 4'h0;
            if (st.par != `PAR_NONE) begin
              next_st.tx_state = tx_par;
            end else if (st.stop != `STOP_NONE) begin
              next_st.tx_state = tx_stop;
            end else begin
              tx_done = 1'b1;
            end
          end
        end
      end
      tx_par: begin
        if (st.tx_cnt == 8'h00) begin
          next_st.tx_cnt = bit_period;
          if (st.stop != `STOP_NONE) begin
            next_st.tx_state = tx_stop;
          end else begin
            tx_done = 1'b1;
          end
        end
      end
      tx_stop: begin
        if (st.tx_cnt == 8'h00) begin
          next_st.tx_cnt = bit_period;
          next_st.tx_bit = st.tx_bit + 4'h1;
          if (st.stop != `STOP_TWO || st.tx_bit == 4'h1) begin
            tx_done = 1'b1;
          end
        end
      end
      default: next_st.tx_state = tx_idle;
    endcase
    if (tx_done) begin
      next_st.tx_state = tx_idle;
      ev[`IRQ_TX]      = !st.irq_sel;
    end
    if (!run_tx) begin
      next_st.tx_state = tx_idle;
    end

    // Line level of the bit being sent
    par_bit = (st.par == `PAR_ZERO) ? 1'b0 : ((^(next_st.tx_shift & len_mask)) ^
              (st.par == `PAR_ODD));
    unique case (next_st.tx_state)
      tx_start: frame_bit = 1'b0;
      tx_data:  frame_bit = next_st.tx_shift[bit_pos(st.dir, len, next_st.tx_bit)];
      tx_par:   frame_bit = par_bit;
      default:  frame_bit = 1'b1;
    endcase
    next_st.tx_line = (next_st.soe && next_st.tx_state != tx_idle) ? frame_bit
                      : next_st.so_lvl;

    // Receiver, sampling at mid-bit
    if (st.rx_state != rx_idle) begin
      next_st.rx_cnt = st.rx_cnt - 8'h01;
    end
    unique case (st.rx_state)
      rx_idle: begin
        if (run_rx && (st.sts ? start_edge : trig)) begin
          next_st.rx_cnt   = {1'b0, st.divider};
          next_st.rx_shift = 9'h000;
          next_st.rx_perr  = 1'b0;
          next_st.rx_state = rx_start;
        end
      end
      rx_start: begin
        if (st.rx_cnt == 8'h00) begin
          next_st.rx_cnt   = bit_period;
          next_st.rx_bit   = 4'h0;
          next_st.rx_state = rx_lvl ? rx_idle : rx_data;
        end
      end
      rx_data: begin
        if (st.rx_cnt == 8'h00) begin
          next_st.rx_cnt = bit_period;
          next_st.rx_bit = st.rx_bit + 4'h1;
          next_st.rx_shift[bit_pos(st.dir, len, st.rx_bit)] = rx_lvl;
          if (st.rx_bit == len - 4'h1) begin
            next_st.rx_bit = 4'h0;
            if (st.par != `PAR_NONE) begin
              next_st.rx_state = rx_par;
            end else if (st.stop != `STOP_NONE) begin
              next_st.rx_state = rx_stop;
            end else begin
              rx_done = 1'b1;
            end
          end
        end
      end
      rx_par: begin
        if (st.rx_cnt == 8'h00) begin
          next_st.rx_cnt  = bit_period;
          next_st.rx_perr = st.par[1] && (rx_lvl != ((^(st.rx_shift & len_mask)) ^
                            (st.par == `PAR_ODD)));
          if (st.stop != `STOP_NONE) begin
            next_st.rx_state = rx_stop;
          end else begin
            rx_done = 1'b1;
          end
        end
      end
      rx_stop: begin
        if (st.rx_cnt == 8'h00) begin
          next_st.rx_cnt = bit_period;
          next_st.rx_bit = st.rx_bit + 4'h1;
          ev[`IRQ_FRM]   = st.eoc && !rx_lvl;
          if (st.stop != `STOP_TWO || st.rx_bit == 4'h1) begin
            rx_done = 1'b1;
          end
        end
      end
      default: next_st.rx_state = rx_idle;
    endcase
    if (rx_done) begin
      next_st.rx_state = rx_idle;
      next_st.rx_data  = next_st.rx_shift & len_mask;
      next_st.rx_full  = 1'b1;
      ev[`IRQ_RX]      = 1'b1;
      ev[`IRQ_PAR]     = st.eoc && next_st.rx_perr;
      ev[`IRQ_OVR]     = st.eoc && st.rx_full;
    end
    if (!run_rx) begin
      next_st.rx_state = rx_idle;
    end

    // Sticky status: a new event wins over a clear in the same cycle
    next_st.ists = (st.ists & ~clr) | ev;
    next_st.irq  = |(next_st.ists & next_st.imask);

    // Pin drivers
    next_st.pin_oe              = ~next_st.pmode;
    next_st.pin_out             = next_st.latch;
    next_st.pin_out[`PIN_TX]    = next_st.latch[`PIN_TX] & next_st.tx_line;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st         <= '0;
      st.so_lvl  <= `RST_SO_LVL;
      st.tx_line <= `RST_SO_LVL;
      st.pmode   <= `RST_PMODE;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign prdata_o    = st.prdata;
  assign pready_o    = st.pready;
  assign pslverr_o   = st.pslverr;
  assign port5_out_o = st.pin_out;
  assign port5_oe_o  = st.pin_oe;
  assign irq_o       = st.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  irq_src_sel_a: assert property ($rose(st.ists[`IRQ_TX]) |->
    (($past(st.tx_state) == tx_idle) == $past(st.irq_sel)))
    else $error("transmit interrupt raised at the wrong point");
  tx_mode_a: assert property (st.tx_state != tx_idle |-> $past(st.txe))
    else $error("transmitter running while transmit disabled");
  rx_mode_a: assert property (st.rx_state != rx_idle |->
    $past(st.ch_mode) == `CH_MODE_UART && $past(st.rxe))
    else $error("receiver running outside asynchronous receive mode");
  err_mask_a: assert property ($rose(st.ists[`IRQ_PAR]) || $rose(st.ists[`IRQ_FRM]) |->
    $past(st.eoc))
    else $error("reception error flagged while masked");
  zero_par_a: assert property (st.tx_state == tx_par && st.soe && st.par == `PAR_ZERO |->
    !st.tx_line)
    else $error("zero parity bit not low");
  msb_first_a: assert property ($rose(st.tx_state == tx_data) && st.soe && !st.dir &&
    st.dlen == `DLEN_8 |-> st.tx_line == st.tx_shift[7])
    else $error("first data bit is not the MSB");
  stop_bit_a: assert property (st.tx_state == tx_stop && st.soe |->
    st.stop != `STOP_NONE && st.tx_line)
    else $error("bad stop bit");
  data_len_a: assert property (st.tx_state == tx_data |-> st.tx_bit < char_len(st.dlen))
    else $error("data bit index beyond character length");
  bit_time_a: assert property (st.tx_state != tx_idle |-> st.tx_cnt <= {st.divider, 1'b1})
    else $error("bit counter exceeds divider");
  idle_level_a: assert property (!st.soe |-> st.tx_line == st.so_lvl)
    else $error("stopped output does not follow level bit");
  pin_dir_a: assert property (port5_oe_o == ~st.pmode)
    else $error("pin direction does not follow mode bits");
  pin_level_a: assert property (port5_out_o[7:5] == st.latch[7:5] &&
    port5_out_o[3:0] == st.latch[3:0] && port5_out_o[4] == (st.latch[4] & st.tx_line))
    else $error("pin level does not follow latch");
  edge_start_a: assert property ($rose(st.rx_state == rx_start) && $past(st.sts) |->
    $past(start_edge))
    else $error("reception started without a start edge");
  sw_start_a: assert property ($rose(st.rx_state == rx_start) && !$past(st.sts) |->
    $past(trig))
    else $error("reception started without software trigger");
  trig_set_a: assert property (ce_i && wr_en && paddr_i == `OFS_START &&
    pwdata_i[`START_GO] |=> st.enabled)
    else $error("start trigger did not enable channel");
  start_low_a: assert property ($rose(st.tx_state == tx_start) && st.soe |-> !st.tx_line)
    else $error("start bit not low");

  cover property (st.tx_state == tx_stop ##1 st.tx_state == tx_idle);
  cover property ($rose(st.ists[`IRQ_RX]));
  cover property ($rose(st.ists[`IRQ_FRM]));
  cover property ($rose(irq_o));
endmodule : async_serial_channel

//--- src/serial_chan_defs.svh
`ifndef SERIAL_CHAN_DEFS_SVH
`define SERIAL_CHAN_DEFS_SVH
// Register byte offsets
`define OFS_MODE     8'h00
`define OFS_COMM     8'h04
`define OFS_DATA     8'h08
`define OFS_OUT_LVL  8'h0C
`define OFS_OUT_EN   8'h10
`define OFS_START    8'h14
`define OFS_LATCH    8'h18
`define OFS_DIR      8'h1C
`define OFS_IRQ_STS  8'h20
`define OFS_IRQ_MSK  8'h24
// Field positions
`define START_GO     0
`define START_HALT   1
`define PIN_TX       4
`define PIN_RX       5
`define IRQ_TX       0
`define IRQ_RX       1
`define IRQ_PAR      2
`define IRQ_FRM      3
`define IRQ_OVR      4
// Field encodings
`define CH_MODE_UART 2'h1
`define PAR_NONE     2'h0
`define PAR_ZERO     2'h1
`define PAR_ODD      2'h3
`define STOP_NONE    2'h0
`define STOP_TWO     2'h2
`define DLEN_9       2'h1
`define DLEN_7       2'h2
`define DLEN_8       2'h3
// Reset values
`define RST_SO_LVL   1'h1
`define RST_PMODE    8'hFF
`endif

//--- src/serial_chan_pkg.sv
package serial_chan_pkg;
  typedef enum logic [2:0] {tx_idle, tx_start, tx_data, tx_par, tx_stop} tx_state_e;
  typedef enum logic [2:0] {rx_idle, rx_start, rx_data, rx_par, rx_stop} rx_state_e;
  typedef struct packed {
    logic             irq_sel;
    logic [1:0]       ch_mode;
    logic             rx_inv;
    logic             sts;
    logic             txe, rxe, eoc, dir;
    logic [1:0]       par, stop, dlen;
    logic [6:0]       divider;
    logic             so_lvl, soe, enabled;
    logic [7:0]       latch, pmode;
    logic [4:0]       ists, imask;
    logic             rx_meta, rx_sync, rx_prev;
    tx_state_e        tx_state;
    logic [7:0]       tx_cnt;
    logic [3:0]       tx_bit;
    logic [8:0]       tx_shift, tx_buf;
    logic             tx_full, tx_line;
    rx_state_e        rx_state;
    logic [7:0]       rx_cnt;
    logic [3:0]       rx_bit;
    logic [8:0]       rx_shift, rx_data;
    logic             rx_full, rx_perr;
    logic [7:0]       pin_out, pin_oe;
    logic             irq, pready, pslverr;
    logic [31:0]      prdata;
  } chan_state_s;
endpackage : serial_chan_pkg
